/* File: hw/scwr_port.sv */
`timescale 1ns/10ps
// Behaviour
// - frame is 27 data bits over 5 address bits, msb first
// - shift on serial clock rise with latch low; latch rise commits word
// - pair divider above 25 or delay above 12 applies after three more edges or at the next latch rise
// - automatic sync on: every latch falling edge emits a sync event
// - register 0 with bit 17 set restores defaults, other bits ignored
// - status pin shows readback when source is readback and push-pull
// - holdover pin defaults to readback source after reset
// - readback address field picks the register, same write may set it
// - after a latched write each serial clock rise with latch low, or any rise with hold set, drives a new readback bit
// - readback is msb first and complete after 27 clocks
// - readback pin carries no valid data after the 27th clock
// - same address for read and write except hold bit and dac count
// - readback returns data bits only, shifted five against write frames
// - low source with inverted push-pull drive makes the pin high
module scwr_port (
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    // serial configuration pins
    input  wire logic        SERIAL_CLOCK_PIN_IN,
    input  wire logic        LATCH_ENABLE_PIN_IN,
    input  wire logic        SERIAL_DATA_PIN_IN,
    // status pins: 0 lock, 1 holdover, 2 input0, 3 input1, 4 sync
    input  wire logic [4:0]  STATUS_SRC_IN,
    output logic      [4:0]  STATUS_PIN_OUT,
    output logic      [4:0]  STATUS_PIN_OE_OUT,
    output logic             SYNC_EVENT_OUT,
    output logic      [65:0] OUTPUT_PAIR_DIVIDER_OUT,
    output logic      [59:0] OUTPUT_PAIR_DIGITAL_DELAY_OUT,
    // AHB-Lite slave
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT
);

    typedef struct packed {
        scwr_pkg::scwr_cfg_t                               cfg;
        logic [scwr_pkg::FRAME_W-1:0]                      sh;
        logic                                              sclk_d;
        logic                                              le_d;
        logic                                              pend;
        logic [2:0]                                        pend_idx;
        logic [scwr_pkg::DIV_W-1:0]                        pend_div;
        logic [scwr_pkg::DLY_W-1:0]                        pend_dly;
        logic [1:0]                                        pend_cnt;
        logic [scwr_pkg::NUM_PAIRS-1:0][scwr_pkg::DIV_W-1:0] div;
        logic [scwr_pkg::NUM_PAIRS-1:0][scwr_pkg::DLY_W-1:0] dly;
        logic [scwr_pkg::DATA_W-1:0]                       rb_sh;
        logic [4:0]                                        rb_cnt;
        logic                                              rb_bit;
        logic [4:0]                                        last_addr;
        logic [4:0]                                        pin_out;
        logic [4:0]                                        pin_oe;
        logic                                              sync_pulse;
        logic [scwr_pkg::SYNC_CNT_W-1:0]                   sync_cnt;
        logic [scwr_pkg::DAC_W-1:0]                        dac;
        logic                                              ahb_wr;
        logic [7:0]                                        ahb_addr;
        logic [31:0]                                       hrdata;
    } scwr_state_t;

    localparam scwr_state_t RST_STATE = '{cfg: scwr_pkg::scwr_defaults(), default: '0};

    scwr_state_t r;
    scwr_state_t n;
    logic [2:0]  pins_s;
    logic        s_sclk;
    logic        s_le;
    logic        s_dat;

    // pins are asynchronous to CLK_IN
    scwr_sync #(
        .W (3)
    ) u_sync (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .d_in     ({SERIAL_CLOCK_PIN_IN, LATCH_ENABLE_PIN_IN, SERIAL_DATA_PIN_IN}),
        .q_out    (pins_s)
    );

    assign s_sclk = pins_s[2];
    assign s_le   = pins_s[1];
    assign s_dat  = pins_s[0];

    // word shifted out for a readback address
    function automatic logic [scwr_pkg::DATA_W-1:0] rb_word(
        input scwr_pkg::scwr_cfg_t       c,
        input logic [4:0]                a,
        input logic [scwr_pkg::DAC_W-1:0] dac
    );
        logic [scwr_pkg::DATA_W-1:0] w;
        w = c[a];
        if (a == scwr_pkg::RB_HOLD_RD_ADDR) begin
            w = 27'(c[scwr_pkg::CTL_REG][scwr_pkg::RB_HOLD_BIT]);
        end else if (a == scwr_pkg::DAC_RD_ADDR) begin
            w = 27'(dac);
        end
        return w;
    endfunction

    // whole next-state computation
    always_comb begin
        logic                         sr;
        logic                         lr;
        logic                         lf;
        logic                         hold;
        logic                         locked;
        logic [4:0]                   a;
        logic [scwr_pkg::DATA_W-1:0]  d;
        logic [scwr_pkg::DIV_W-1:0]   nd;
        logic [scwr_pkg::DLY_W-1:0]   ny;
        logic [4:0]                   rba;
        logic [4:0]                   mux;
        logic [2:0]                   typ;
        logic                         src;
        sr     = s_sclk && !r.sclk_d;
        lr     = s_le && !r.le_d;
        lf     = !s_le && r.le_d;
        hold   = r.cfg[scwr_pkg::CTL_REG][scwr_pkg::RB_HOLD_BIT];
        locked = r.cfg[scwr_pkg::CTL_REG][scwr_pkg::WLOCK_BIT];
        a      = r.sh[scwr_pkg::ADDR_W-1:0];
        d      = r.sh[scwr_pkg::FRAME_W-1:scwr_pkg::ADDR_W];
        nd     = d[scwr_pkg::DIV_LSB +: scwr_pkg::DIV_W];
        ny     = d[scwr_pkg::DLY_LSB +: scwr_pkg::DLY_W];
        rba    = '0;
        mux    = '0;
        typ    = '0;
        src    = 1'b0;
        n            = r;
        n.sclk_d     = s_sclk;
        n.le_d       = s_le;
        n.sync_pulse = 1'b0;

        // write shifter: msb arrives first, so shift toward the top
        if (sr && !s_le) begin
            n.sh = {r.sh[scwr_pkg::FRAME_W-2:0], s_dat};
        end

        // large divider or delay waits for three more serial clock rises or the next latch rise
        if (sr && r.pend) begin
            n.pend_cnt = r.pend_cnt + 2'h1;
        end
        if (r.pend && ((sr && r.pend_cnt == scwr_pkg::EXTRA_EDGES - 2'h1) || lr)) begin
            n.div[r.pend_idx] = r.pend_div;
            n.dly[r.pend_idx] = r.pend_dly;
            n.pend            = 1'b0;
        end

        // readback shifter; with hold clear it only runs while latch is low
        if (sr && (!s_le || hold)) begin
            if (r.rb_cnt < scwr_pkg::RB_LEN) begin
                n.rb_bit = r.rb_sh[scwr_pkg::DATA_W-1];
                n.rb_sh  = {r.rb_sh[scwr_pkg::DATA_W-2:0], 1'b0};
                n.rb_cnt = r.rb_cnt + 5'h01;
            end else begin
                n.rb_bit = 1'b0;
            end
        end

        // latch rising edge commits the shifted frame
        if (lr) begin
            n.last_addr = a;
            if (a == scwr_pkg::RESET_ADDR && d[scwr_pkg::RESET_BIT]) begin
                n.cfg  = scwr_pkg::scwr_defaults();
                n.div  = '0;
                n.dly  = '0;
                n.pend = 1'b0;
            end else if (!locked || a == scwr_pkg::CTL_ADDR) begin
                n.cfg[a] = d;
                if (a < 5'(scwr_pkg::NUM_PAIRS)) begin
                    if (nd > scwr_pkg::DIV_LIMIT || ny > scwr_pkg::DLY_LIMIT) begin
                        n.pend     = 1'b1;
                        n.pend_idx = a[2:0];
                        n.pend_div = nd;
                        n.pend_dly = ny;
                        n.pend_cnt = 2'h0;
                    end else begin
                        n.div[a[2:0]] = nd;
                        n.dly[a[2:0]] = ny;
                    end
                end
            end
            // the address may come from this very write
            rba      = n.cfg[scwr_pkg::CTL_REG][scwr_pkg::RB_ADDR_LSB +: 5];
            n.rb_sh  = rb_word(n.cfg, rba, r.dac);
            n.rb_cnt = 5'h00;
            n.rb_bit = 1'b0;
        end

        // sync event on latch fall; the host has already given the extra edges
        if (lf && r.cfg[scwr_pkg::SYNC_REG][scwr_pkg::SYNC_AUTO_BIT]) begin
            n.sync_pulse = 1'b1;
            n.sync_cnt   = r.sync_cnt + 16'h0001;
        end

        // status pin source and drive type
        for (int i = 0; i < scwr_pkg::NUM_PINS; i++) begin
            mux = n.cfg[scwr_pkg::PIN_REG[i]][scwr_pkg::PIN_MUX_LSB[i] +: scwr_pkg::MUX_W];
            typ = n.cfg[scwr_pkg::PIN_REG[i]][scwr_pkg::PIN_TYPE_LSB[i] +: scwr_pkg::TYPE_W];
            if (mux == scwr_pkg::MUX_LOW) begin
                src = 1'b0;
            end else if (mux == scwr_pkg::MUX_READBACK) begin
                src = n.rb_bit;
            end else begin
                src = STATUS_SRC_IN[i];
            end
            case (typ)
                scwr_pkg::TYPE_PP: begin
                    n.pin_out[i] = src;
                    n.pin_oe[i]  = 1'b1;
                end
                scwr_pkg::TYPE_PP_INV: begin
                    n.pin_out[i] = !src;
                    n.pin_oe[i]  = 1'b1;
                end
                default: begin
                    n.pin_out[i] = 1'b0;                      // other types float the pin
                    n.pin_oe[i]  = 1'b0;
                end
            endcase
        end

        // bus data phase write comes first so a following read sees it
        if (r.ahb_wr && r.ahb_addr == scwr_pkg::AHB_CTRL_OFS) begin
            n.dac = HWDATA_IN[scwr_pkg::DAC_W-1:0];
        end
        n.ahb_wr = 1'b0;
        if (HSEL_IN && HTRANS_IN[1] && HREADY_IN) begin
            n.ahb_wr   = HWRITE_IN;
            n.ahb_addr = HADDR_IN[7:0];
            n.hrdata   = 32'h0000_0000;
            if (!HWRITE_IN) begin
                case (HADDR_IN[7:0])
                    scwr_pkg::AHB_CTRL_OFS: begin
                        n.hrdata = 32'(n.dac);
                    end
                    scwr_pkg::AHB_STATUS_OFS: begin
                        n.hrdata[scwr_pkg::ST_ADDR_LSB +: 5]  = r.last_addr;
                        n.hrdata[scwr_pkg::ST_PEND_BIT]       = r.pend;
                        n.hrdata[scwr_pkg::ST_RBCNT_LSB +: 5] = r.rb_cnt;
                        n.hrdata[scwr_pkg::ST_LOCK_BIT]       = locked;
                    end
                    scwr_pkg::AHB_SYNC_OFS: begin
                        n.hrdata = 32'(r.sync_cnt);
                    end
                    default: begin
                        n.hrdata = 32'h0000_0000;             // unmapped reads zero
                    end
                endcase
            end
        end
    end

    // single state register, reset to power-on defaults
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            r <= RST_STATE;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register; bus ready and response are constants
    assign STATUS_PIN_OUT                = r.pin_out;
    assign STATUS_PIN_OE_OUT             = r.pin_oe;
    assign SYNC_EVENT_OUT                = r.sync_pulse;
    assign OUTPUT_PAIR_DIVIDER_OUT       = r.div;
    assign OUTPUT_PAIR_DIGITAL_DELAY_OUT = r.dly;
    assign HRDATA_OUT                    = r.hrdata;
    assign HREADYOUT_OUT                 = 1'b1;             // zero wait states
    assign HRESP_OUT                     = 1'b0;             // always OKAY

endmodule // scwr_port

/* File: hw/scwr_pkg.sv */
package scwr_pkg;

    // frame layout
    localparam int FRAME_W   = 32;
    localparam int ADDR_W    = 5;
    localparam int DATA_W    = 27;
    localparam int NUM_REGS  = 32;
    localparam int NUM_PAIRS = 6;
    localparam int NUM_PINS  = 5;

    // output pair fields inside registers 0..5 (data-field positions)
    localparam int DIV_LSB   = 0;
    localparam int DIV_W     = 11;
    localparam int DLY_LSB   = 13;
    localparam int DLY_W     = 10;
    localparam int RESET_BIT = 12;                       // frame bit 17 of register 0
    localparam logic [4:0]  RESET_ADDR  = 5'h00;
    localparam logic [10:0] DIV_LIMIT   = 11'h019;       // 25
    localparam logic [9:0]  DLY_LIMIT   = 10'h00c;       // 12
    localparam logic [1:0]  EXTRA_EDGES = 2'h3;
    localparam logic [4:0]  RB_LEN      = 5'h1b;         // 27 readback bits

    // control bits held in configuration registers
    localparam int SYNC_REG      = 11;
    localparam int SYNC_AUTO_BIT = 4;
    localparam int CTL_REG       = 31;
    localparam int RB_ADDR_LSB   = 0;
    localparam int RB_HOLD_BIT   = 5;
    localparam int WLOCK_BIT     = 6;
    localparam logic [4:0] CTL_ADDR        = 5'h1f;
    localparam logic [4:0] RB_HOLD_RD_ADDR = 5'h16;
    localparam logic [4:0] DAC_RD_ADDR     = 5'h17;
    localparam int DAC_W = 10;

    // status pin control: 0 lock, 1 holdover, 2 input0, 3 input1, 4 sync
    localparam int MUX_W  = 5;
    localparam int TYPE_W = 3;
    localparam logic [4:0] MUX_LOW      = 5'h00;
    localparam logic [4:0] MUX_READBACK = 5'h06;
    localparam logic [2:0] TYPE_PP      = 3'h3;
    localparam logic [2:0] TYPE_PP_INV  = 3'h4;
    localparam int PIN_HOLDOVER = 1;
    localparam int PIN_REG      [NUM_PINS] = '{12, 13, 13, 14, 11};
    localparam int PIN_MUX_LSB  [NUM_PINS] = '{3, 19, 11, 19, 11};
    localparam int PIN_TYPE_LSB [NUM_PINS] = '{0, 16, 8, 16, 8};

    // bus register map and status fields
    localparam logic [7:0] AHB_CTRL_OFS   = 8'h00;
    localparam logic [7:0] AHB_STATUS_OFS = 8'h04;
    localparam logic [7:0] AHB_SYNC_OFS   = 8'h08;
    localparam int ST_ADDR_LSB  = 0;
    localparam int ST_PEND_BIT  = 5;
    localparam int ST_RBCNT_LSB = 6;
    localparam int ST_LOCK_BIT  = 11;
    localparam int SYNC_CNT_W   = 16;

    typedef logic [NUM_REGS-1:0][DATA_W-1:0] scwr_cfg_t;

    // power-on contents of the register file
    function automatic scwr_cfg_t scwr_defaults();
        scwr_cfg_t d;
        d = '0;
        for (int i = 0; i < NUM_PINS; i++) begin
            d[PIN_REG[i]][PIN_TYPE_LSB[i] +: TYPE_W] = TYPE_PP;
        end
        d[PIN_REG[PIN_HOLDOVER]][PIN_MUX_LSB[PIN_HOLDOVER] +: MUX_W] = MUX_READBACK;
        return d;
    endfunction

endpackage

/* File: hw/scwr_sync.sv */
`timescale 1ns/10ps
// two-stage synchroniser for pin levels
module scwr_sync #(
    parameter int W = 3
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } scwr_sync_t;

    scwr_sync_t s_r;
    scwr_sync_t s_nxt;

    // first stage feeds only the second stage
    always_comb begin
        s_nxt.meta   = d_in;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_out = s_r.stable;

endmodule // scwr_sync

/* File: testbench/scwr_port_chk.sv */
`timescale 1ns/10ps
// port-level checker; timing windows are counted from raw pin edges
module scwr_port_chk (
    input wire logic        CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic        SERIAL_CLOCK_PIN_IN,
    input wire logic        LATCH_ENABLE_PIN_IN,
    input wire logic [4:0]  STATUS_PIN_OUT,
    input wire logic [4:0]  STATUS_PIN_OE_OUT,
    input wire logic        SYNC_EVENT_OUT,
    input wire logic [65:0] OUTPUT_PAIR_DIVIDER_OUT,
    input wire logic [59:0] OUTPUT_PAIR_DIGITAL_DELAY_OUT,
    input wire logic        HSEL_IN,
    input wire logic [1:0]  HTRANS_IN,
    input wire logic        HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic        HREADYOUT_OUT,
    input wire logic        HRESP_OUT
);
    logic       sclk_r;
    logic       le_r;
    logic [7:0] gap_r;

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    // cycles since the last rise on either serial pin, saturating so it never wraps
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sclk_r <= 1'b0;
            le_r   <= 1'b0;
            gap_r  <= 8'hff;
        end else begin
            sclk_r <= SERIAL_CLOCK_PIN_IN;
            le_r   <= LATCH_ENABLE_PIN_IN;
            if ((SERIAL_CLOCK_PIN_IN && !sclk_r) || (LATCH_ENABLE_PIN_IN && !le_r)) begin
                gap_r <= 8'h00;
            end else if (gap_r != 8'hff) begin
                gap_r <= gap_r + 8'h01;
            end
        end
    end

    sequence s_sync_quiet;
        !SYNC_EVENT_OUT [*3];
    endsequence

    a_sync_one_cycle: assert property ($rose(SYNC_EVENT_OUT) |=> s_sync_quiet)
        else $error("sync event wider than one cycle");
    a_sync_after_fall: assert property (SYNC_EVENT_OUT |-> !LATCH_ENABLE_PIN_IN &&
        ($past(LATCH_ENABLE_PIN_IN, 2) || $past(LATCH_ENABLE_PIN_IN, 3) ||
         $past(LATCH_ENABLE_PIN_IN, 4) || $past(LATCH_ENABLE_PIN_IN, 5) ||
         $past(LATCH_ENABLE_PIN_IN, 6)))
        else $error("sync event without a latch falling edge");
    a_pin_drive_gate: assert property ((STATUS_PIN_OUT & ~STATUS_PIN_OE_OUT) == 5'h00)
        else $error("status pin level set while not driven");
    a_div_needs_edge: assert property (!$stable(OUTPUT_PAIR_DIVIDER_OUT) |-> gap_r < 8'h0a)
        else $error("divider changed with no serial edge");
    a_dly_needs_edge: assert property (
        !$stable(OUTPUT_PAIR_DIGITAL_DELAY_OUT) |-> gap_r < 8'h0a)
        else $error("delay changed with no serial edge");
    a_rdata_stands: assert property (!$past(HSEL_IN && HTRANS_IN[1] && HREADY_IN) |->
        $stable(HRDATA_OUT))
        else $error("read data moved without an access");
    a_bus_zero_wait: assert property (HREADYOUT_OUT == 1'b1)
        else $error("bus wait state inserted");
    a_bus_resp_okay: assert property (HRESP_OUT == 1'b0)
        else $error("bus error response");
endmodule // scwr_port_chk

/* File: testbench/scwr_host.sv */
`timescale 1ns/10ps
// host side of the serial link; the clock stands low between frames
module scwr_host (
    input  wire logic clk_in,
    input  wire logic rb_pin_in,
    output logic      sclk_out,
    output logic      le_out,
    output logic      sdata_out
);
    // levels held 40 ns, far above the three-cycle pin sampling
    task automatic half();
        repeat (10) @(posedge clk_in);
    endtask

    // one clock pulse, ending low so latch may fall next
    task automatic pulse();
        sclk_out <= 1'b1;
        half();
        sclk_out <= 1'b0;
        half();
    endtask

    // word msb first, then latch raised and left high
    task automatic send(input logic [26:0] d, input logic [4:0] a);
        logic [31:0] w;
        w = {d, a};
        for (int i = 31; i >= 0; i--) begin
            sdata_out <= w[i];
            half();
            pulse();
        end
        // released data line shows the inverse, never a stale copy
        sdata_out <= ~w[0];
        le_out    <= 1'b1;
        half();
    endtask

    // latch falls only while the clock is parked low
    task automatic drop();
        le_out <= 1'b0;
        half();
    endtask

    // full write, optional edges while latch stays high
    task automatic frame(input logic [26:0] d, input logic [4:0] a, input int n_hi);
        send(d, a);
        repeat (n_hi) pulse();
        drop();
    endtask

    // each bit leaves on the rise and is taken as the clock falls
    task automatic readback(output logic [26:0] q);
        for (int i = 26; i >= 0; i--) begin
            sclk_out <= 1'b1;
            half();
            q[i] = rb_pin_in;
            sclk_out <= 1'b0;
            half();
        end
    endtask

    initial begin
        sclk_out  = 1'b0;
        le_out    = 1'b0;
        sdata_out = 1'b0;
    end
endmodule // scwr_host

/* File: testbench/scwr_port_tb.sv */
`timescale 1ns/10ps
// frames through the host model, registers through bus reads and writes
module scwr_port_tb;
    logic        clk;
    logic        rst_n;
    logic        sclk;
    logic        le;
    logic        sdata;
    logic        hwrite;
    logic        hready;
    logic        sync_ev;
    logic [1:0]  htrans;
    logic [4:0]  pin;
    logic [4:0]  oe;
    logic [26:0] q;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [65:0] div;
    logic [59:0] dly;
    int          error_cnt;
    int          checked;
    int          cyc;
    int          sync_seen;

    scwr_port u_scwr_port (
        .CLK_IN(clk), .RST_N_IN(rst_n), .SERIAL_CLOCK_PIN_IN(sclk),
        .LATCH_ENABLE_PIN_IN(le), .SERIAL_DATA_PIN_IN(sdata), .STATUS_SRC_IN(5'h00),
        .STATUS_PIN_OUT(pin), .STATUS_PIN_OE_OUT(oe), .SYNC_EVENT_OUT(sync_ev),
        .OUTPUT_PAIR_DIVIDER_OUT(div), .OUTPUT_PAIR_DIGITAL_DELAY_OUT(dly),
        .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
        .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hready), .HRESP_OUT()
    );
    scwr_host u_scwr_host (.clk_in(clk), .rb_pin_in(pin[scwr_pkg::PIN_HOLDOVER]),
        .sclk_out(sclk), .le_out(le), .sdata_out(sdata));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [65:0] seen, input logic [65:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // single word transfer; read data taken at the data phase's ready edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    // cut a hang short well past the expected run of about 20k cycles
    always @(posedge clk) begin
        cyc++;
        if (sync_ev === 1'b1) sync_seen++;
        if (cyc == 40000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        rst_n  = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("pin_oe", oe, 5'h1f);
        chk("pin_lvl", pin, 5'h00);
        // small values apply with no extra edges
        u_scwr_host.frame(27'h000a014, 5'h03, 0);
        chk("div3", div[33 +: 11], 11'h014);
        chk("dly3", dly[30 +: 10], 10'h005);
        ahb(1'b0, scwr_pkg::AHB_STATUS_OFS, 32'h0);
        chk("last_addr", rd[4:0], 5'h03);
        u_scwr_host.frame(27'h0000003, 5'h1f, 0);
        u_scwr_host.readback(q);
        chk("rb_reg3", q, 27'h000a014);
        // the tuning count reads back through its own address
        ahb(1'b1, scwr_pkg::AHB_CTRL_OFS, 32'h2a5);
        ahb(1'b0, scwr_pkg::AHB_CTRL_OFS, 32'h0);
        chk("ctrl", rd, 32'h2a5);
        ahb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", rd, 32'h0);
        u_scwr_host.frame(27'h0000017, 5'h1f, 0);
        u_scwr_host.readback(q);
        chk("rb_dac", q, 27'h00002a5);
        // large divider waits; rewriting the same word supplies the edges
        u_scwr_host.frame(27'h0000064, 5'h00, 0);
        chk("div0_wait", div[0 +: 11], 11'h000);
        ahb(1'b0, scwr_pkg::AHB_STATUS_OFS, 32'h0);
        chk("pending", rd[5], 1'b1);
        u_scwr_host.frame(27'h0000064, 5'h00, 0);
        chk("div0", div[0 +: 11], 11'h064);
        // reset bit drops the divider field and zeroes every pair
        u_scwr_host.frame(27'h0001007, 5'h00, 0);
        chk("div_rst", div, 66'h0);
        u_scwr_host.frame(27'h0000009, 5'h00, 0);
        chk("div0_again", div[0 +: 11], 11'h009);
        // alternating pattern into register 9, then read it back
        u_scwr_host.frame(27'h5555555, 5'h09, 0);
        u_scwr_host.frame(27'h0000009, 5'h1f, 0);
        u_scwr_host.readback(q);
        chk("rb_reg9", q, 27'h5555555);
        // hold set: the read runs with latch still high, latch drops after
        u_scwr_host.send(27'h0000029, 5'h1f);
        u_scwr_host.readback(q);
        u_scwr_host.drop();
        chk("rb_held", q, 27'h5555555);
        u_scwr_host.send(27'h0000036, 5'h1f);
        u_scwr_host.readback(q);
        u_scwr_host.drop();
        chk("rb_hold_bit", q, 27'h0000001);
        // lock pin held low, flipped by drive type alone
        u_scwr_host.frame(27'h0000003, 5'h0c, 0);
        chk("lock_lo", {oe[0], pin[0]}, 2'b10);
        u_scwr_host.frame(27'h0000004, 5'h0c, 0);
        chk("lock_hi", {oe[0], pin[0]}, 2'b11);
        // write lock refuses every register but 31, and the register 0 reset bit, until cleared again
        u_scwr_host.frame(27'h0000040, 5'h1f, 0);
        u_scwr_host.frame(27'h0000003, 5'h0c, 0);
        chk("lock_kept", {oe[0], pin[0]}, 2'b11);
        ahb(1'b0, scwr_pkg::AHB_STATUS_OFS, 32'h0);
        chk("wlock", rd[11], 1'b1);
        u_scwr_host.frame(27'h0000000, 5'h1f, 0);
        // automatic sync: one event per latch fall
        chk("no_sync", sync_seen, 0);
        u_scwr_host.frame(27'h0000010, 5'h0b, 0);
        chk("sync1", sync_seen, 1);
        u_scwr_host.frame(27'h000003c, 5'h01, 3);
        chk("div1", div[11 +: 11], 11'h03c);
        chk("sync2", sync_seen, 2);
        ahb(1'b0, scwr_pkg::AHB_SYNC_OFS, 32'h0);
        chk("sync_cnt", rd[15:0], 16'h0002);
        report_and_stop();
    end
endmodule // scwr_port_tb

bind scwr_port scwr_port_chk u_scwr_port_chk (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .SERIAL_CLOCK_PIN_IN(SERIAL_CLOCK_PIN_IN),
    .LATCH_ENABLE_PIN_IN(LATCH_ENABLE_PIN_IN), .STATUS_PIN_OUT(STATUS_PIN_OUT),
    .STATUS_PIN_OE_OUT(STATUS_PIN_OE_OUT), .SYNC_EVENT_OUT(SYNC_EVENT_OUT),
    .OUTPUT_PAIR_DIVIDER_OUT(OUTPUT_PAIR_DIVIDER_OUT),
    .OUTPUT_PAIR_DIGITAL_DELAY_OUT(OUTPUT_PAIR_DIGITAL_DELAY_OUT), .HSEL_IN(HSEL_IN),
    .HTRANS_IN(HTRANS_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
    .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT));
